// [rtl/deser_gpio_audio_pin_control.sv]
// general-purpose pin and audio output control of the deserializer
`timescale 1ns/1ps
module deser_gpio_audio_pin_control
  import deser_pin_pkg::*;
(
  input wire logic sys_clk_in, // system clock, 250 MHz
  input wire logic sys_rst_in, // async reset, active high
  input wire logic link_clk_in, // link clock
  input wire logic reg_wr_in, // local register write strobe
  input wire logic reg_rd_in, // local register read strobe
  input wire logic [7:0] reg_addr_in, // local register address
  input wire logic [7:0] reg_wdata_in, // local write data
  output logic [7:0] reg_rdata_out, // local read data
  output logic reg_rvalid_out, // local read data valid
  input wire logic rem_wr_in, // remote write strobe from control channel
  input wire logic rem_rd_in, // remote read strobe from control channel
  input wire logic [7:0] rem_addr_in, // remote register address
  input wire logic [7:0] rem_wdata_in, // remote write data
  output logic [7:0] rem_rdata_out, // remote read data
  output logic rem_rvalid_out, // remote read data valid
  output logic rem_busy_out, // remote access refused this cycle
  input wire logic backward_compat_select_in, // backward compatibility mode
  input wire logic ser_full_feature_in, // partner serializer is full-featured
  input wire logic ser_18bit_mode_in, // auto-loaded 18-bit video mode
  input wire logic ser_island_mode_in, // auto-loaded data-island transport
  input wire logic audio_cfg_disable_in, // software selects frame transport
  input wire logic surround_en_in, // surround requested
  input wire logic repeater_mode_in, // repeater mode
  input wire logic [3:0] fwd_gpio_in, // forward-channel pin levels, link domain
  output logic [3:0] bc_gpio_out, // back-channel pin levels, link domain
  output logic [3:0] bc_gpio_valid_out, // pins sent as inputs, link domain
  input wire logic [1:0] gpio01_pad_in, // pads of pins 0,1
  output logic [1:0] gpio01_pad_out, // pad drive value
  output logic [1:0] gpio01_pad_oe_out, // pad drive enable
  input wire logic [1:0] cd_pad_in, // pads shared by pins 2,3 and lanes c,d
  output logic [1:0] cd_pad_out, // pad drive value
  output logic [1:0] cd_pad_oe_out, // pad drive enable
  input wire logic [3:0] reg_pad_in, // pads of pins 5..8, also audio inputs
  output logic [3:0] reg_pad_out, // pad drive value
  output logic [3:0] reg_pad_oe_out, // pad drive enable
  input wire logic [3:0] link_audio_sd_in, // lanes a..d from the link
  input wire logic link_audio_ws_in, // word select from the link
  input wire logic audio_in_ws_in, // local audio input word select
  output logic audio_bit_clk_out, // audio bit clock
  output logic audio_word_select_out, // audio word select
  output logic audio_data_a_out, // audio lane a
  output logic audio_data_b_out // audio lane b
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [7:0] gpio0_config;
  logic [7:0] gpio1_gpio2_config;
  logic [7:0] gpio3_config;
  logic [7:0] reg_gpio5_6_config;
  logic [7:0] reg_gpio7_8_config;
  logic acc_wr;
  logic acc_rd;
  logic acc_local;
  logic [7:0] acc_addr;
  logic [7:0] acc_wdata;
  logic [7:0] next_rdata;
  logic [7:0] input_levels_low;
  logic [7:0] input_levels_high;
  pin_mode_t link_mode [4];
  pin_mode_t reg_mode [4];
  logic [3:0] link_code [4];
  logic [3:0] reg_code [4];
  logic [7:0] pad_level;
  logic [3:0] fwd_level;
  logic [3:0] link_in_mask;
  logic [3:0] reg_in_mask;
  logic [3:0] reg_owned;
  logic [3:0] link_out_val;
  logic [3:0] link_out_en;
  logic [3:0] lane_en;
  logic use_local;
  logic [21:0] to_link;
  logic [21:0] at_link;
  logic [3:0] lane_sd;
  audio_ctrl_if audio_ctrl ();

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  function automatic pin_mode_t decode(input logic [3:0] code, input logic linked);
    pin_mode_t mode;
    mode = PIN_OFF;
    unique case (code)
      CODE_FWD_OUT: mode = linked ? PIN_FWD_OUT : PIN_OFF;
      CODE_INPUT: mode = PIN_INPUT;
      CODE_LOCAL_LOW: mode = PIN_OUT_LOW;
      CODE_LOCAL_HIGH: mode = PIN_OUT_HIGH;
      default: mode = PIN_OFF;
    endcase
    return mode;
  endfunction

  always_comb begin
    link_code[0] = gpio0_config[NIBBLE_LO+:4];
    link_code[1] = gpio1_gpio2_config[NIBBLE_LO+:4];
    link_code[2] = gpio1_gpio2_config[NIBBLE_HI+:4];
    link_code[3] = gpio3_config[NIBBLE_LO+:4];
    reg_code[0] = reg_gpio5_6_config[NIBBLE_LO+:4];
    reg_code[1] = reg_gpio5_6_config[NIBBLE_HI+:4];
    reg_code[2] = reg_gpio7_8_config[NIBBLE_LO+:4];
    reg_code[3] = reg_gpio7_8_config[NIBBLE_HI+:4];
  end

  // ---------------------------------------------------------------
  // register access: local wins, remote told to retry
  // ---------------------------------------------------------------
  always_comb begin
    acc_local = reg_wr_in | reg_rd_in;
    rem_busy_out = acc_local & (rem_wr_in | rem_rd_in);
    acc_wr = acc_local ? reg_wr_in : rem_wr_in;
    acc_rd = acc_local ? reg_rd_in : rem_rd_in;
    acc_addr = acc_local ? reg_addr_in : rem_addr_in;
    acc_wdata = acc_local ? reg_wdata_in : rem_wdata_in;
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      gpio0_config <= CONFIG_RESET;
      gpio1_gpio2_config <= CONFIG_RESET;
      gpio3_config <= CONFIG_RESET;
      reg_gpio5_6_config <= CONFIG_RESET;
      reg_gpio7_8_config <= CONFIG_RESET;
    end else if (acc_wr) begin
      unique case (acc_addr)
        ADDR_GPIO0_CONFIG: gpio0_config <= acc_wdata;
        ADDR_GPIO1_GPIO2_CONFIG: gpio1_gpio2_config <= acc_wdata;
        ADDR_GPIO3_CONFIG: gpio3_config <= acc_wdata;
        ADDR_REG_GPIO5_6_CONFIG: reg_gpio5_6_config <= acc_wdata;
        ADDR_REG_GPIO7_8_CONFIG: reg_gpio7_8_config <= acc_wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    input_levels_low = '0;
    input_levels_high = '0;
    input_levels_low[STAT_GPIO0_BIT+:4] = pad_level[3:0] & link_in_mask;
    input_levels_low[STAT_REG5_BIT+:3] = pad_level[6:4] & reg_in_mask[2:0];
    input_levels_high[STAT_REG8_BIT] = pad_level[7] & reg_in_mask[3];
    unique case (acc_addr)
      ADDR_GPIO0_CONFIG: next_rdata = gpio0_config;
      ADDR_GPIO1_GPIO2_CONFIG: next_rdata = gpio1_gpio2_config;
      ADDR_GPIO3_CONFIG: next_rdata = gpio3_config;
      ADDR_REG_GPIO5_6_CONFIG: next_rdata = reg_gpio5_6_config;
      ADDR_REG_GPIO7_8_CONFIG: next_rdata = reg_gpio7_8_config;
      ADDR_INPUT_LEVELS_LOW: next_rdata = input_levels_low;
      ADDR_INPUT_LEVELS_HIGH: next_rdata = input_levels_high;
      default: next_rdata = RDATA_UNMAPPED;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= RDATA_UNMAPPED;
      reg_rvalid_out <= 1'b0;
      rem_rdata_out <= RDATA_UNMAPPED;
      rem_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      rem_rvalid_out <= rem_rd_in & ~acc_local;
      if (reg_rd_in) begin
        reg_rdata_out <= next_rdata;
      end
      if (rem_rd_in & ~acc_local) begin
        rem_rdata_out <= next_rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // input synchronisers, system side
  // ---------------------------------------------------------------
  level_sync #(.WIDTH(8)) u_pad_sync (
    .clk_in(sys_clk_in),
    .rst_in(sys_rst_in),
    .d_in({reg_pad_in, cd_pad_in, gpio01_pad_in}),
    .q_out(pad_level)
  );

  level_sync #(.WIDTH(4)) u_fwd_sync (
    .clk_in(sys_clk_in),
    .rst_in(sys_rst_in),
    .d_in(fwd_gpio_in),
    .q_out(fwd_level)
  );

  // ---------------------------------------------------------------
  // per-pin control
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_pin
    always_comb begin
      link_mode[i] = decode(link_code[i], 1'b1);
      reg_mode[i] = decode(reg_code[i], 1'b0);
      link_in_mask[i] = (link_mode[i] == PIN_INPUT);
      reg_in_mask[i] = (reg_mode[i] == PIN_INPUT);
      reg_owned[i] = (reg_mode[i] != PIN_OFF);
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        link_out_val[i] <= 1'b0;
        link_out_en[i] <= 1'b0;
        reg_pad_out[i] <= 1'b0;
        reg_pad_oe_out[i] <= 1'b0;
      end else begin
        link_out_val[i] <= (link_mode[i] == PIN_FWD_OUT) ? fwd_level[i] :
                           (link_mode[i] == PIN_OUT_HIGH);
        link_out_en[i] <= (link_mode[i] != PIN_OFF) && (link_mode[i] != PIN_INPUT);
        reg_pad_out[i] <= (reg_mode[i] == PIN_OUT_HIGH);
        reg_pad_oe_out[i] <= (reg_mode[i] == PIN_OUT_HIGH) || (reg_mode[i] == PIN_OUT_LOW);
      end
    end
  end

  // ---------------------------------------------------------------
  // shared pads: a configured pin takes the pad from its audio lane
  // ---------------------------------------------------------------
  always_comb begin
    gpio01_pad_out = link_out_val[1:0];
    gpio01_pad_oe_out = link_out_en[1:0];
    for (int k = 0; k < 2; k++) begin
      if (link_mode[k+2] != PIN_OFF) begin
        cd_pad_out[k] = link_out_val[k+2];
        cd_pad_oe_out[k] = link_out_en[k+2];
      end else begin
        cd_pad_out[k] = lane_sd[k+2];
        cd_pad_oe_out[k] = lane_en[k+2];
      end
    end
  end

  // ---------------------------------------------------------------
  // audio lane selection
  // ---------------------------------------------------------------
  // lanes chosen here, on the system side, so pad enables match the data
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lane_en <= LANES_NONE;
    end else if (backward_compat_select_in) begin
      lane_en <= LANES_NONE;
    end else if (audio_cfg_disable_in || !ser_island_mode_in) begin
      lane_en <= LANES_A;
    end else if (!ser_full_feature_in) begin
      lane_en <= ser_18bit_mode_in ? LANES_AB : LANES_A;
    end else begin
      lane_en <= surround_en_in ? LANES_ALL : LANES_AB;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      use_local <= 1'b0;
    end else begin
      use_local <= repeater_mode_in & ~backward_compat_select_in;
    end
  end

  // ---------------------------------------------------------------
  // crossing into the link domain
  // ---------------------------------------------------------------
  always_comb begin
    to_link = {audio_in_ws_in, reg_pad_in, cd_pad_in, gpio01_pad_in,
               link_in_mask, reg_owned, use_local, lane_en};
  end

  level_sync #(.WIDTH(22)) u_link_sync (
    .clk_in(link_clk_in),
    .rst_in(sys_rst_in),
    .d_in(to_link),
    .q_out(at_link)
  );

  // back channel only ever carries pins 0..3
  always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bc_gpio_out <= '0;
      bc_gpio_valid_out <= '0;
    end else begin
      bc_gpio_out <= at_link[16:13] & at_link[12:9];
      bc_gpio_valid_out <= at_link[12:9];
    end
  end

  assign audio_ctrl.lane_en = at_link[3:0];
  assign audio_ctrl.use_local = at_link[4];
  assign audio_ctrl.local_sd = at_link[20:17] & ~at_link[8:5];
  assign audio_ctrl.local_ws = at_link[21];

  audio_lane_out u_audio (
    .link_clk_in(link_clk_in),
    .rst_in(sys_rst_in),
    .ctrl(audio_ctrl.lane),
    .link_sd_in(link_audio_sd_in),
    .link_ws_in(link_audio_ws_in),
    .bit_clk_out(audio_bit_clk_out),
    .ws_out(audio_word_select_out),
    .sd_out(lane_sd)
  );

  assign audio_data_a_out = lane_sd[LANE_A];
  assign audio_data_b_out = lane_sd[LANE_B];

endmodule

// [rtl/deser_pin_pkg.sv]
// constants and types shared by the pin-control block
package deser_pin_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_GPIO0_CONFIG = 8'h1d;
  localparam logic [7:0] ADDR_GPIO1_GPIO2_CONFIG = 8'h1e;
  localparam logic [7:0] ADDR_GPIO3_CONFIG = 8'h1f;
  localparam logic [7:0] ADDR_REG_GPIO5_6_CONFIG = 8'h20;
  localparam logic [7:0] ADDR_REG_GPIO7_8_CONFIG = 8'h21;
  localparam logic [7:0] ADDR_INPUT_LEVELS_LOW = 8'h6e;
  localparam logic [7:0] ADDR_INPUT_LEVELS_HIGH = 8'h6f;

  // ---------------------------------------------------------------
  // reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  localparam int NIBBLE_LO = 0;
  localparam int NIBBLE_HI = 4;
  // input status bit positions: pins 0..3 in low byte, 5..7 above, 8 in high byte
  localparam int STAT_GPIO0_BIT = 0;
  localparam int STAT_REG5_BIT = 5;
  localparam int STAT_REG8_BIT = 0;

  // ---------------------------------------------------------------
  // configuration nibble codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CODE_FWD_OUT = 4'h5;
  localparam logic [3:0] CODE_INPUT = 4'h3;
  localparam logic [3:0] CODE_LOCAL_LOW = 4'h1;
  localparam logic [3:0] CODE_LOCAL_HIGH = 4'h9;

  typedef enum logic [2:0] {
    PIN_OFF,
    PIN_FWD_OUT,
    PIN_INPUT,
    PIN_OUT_LOW,
    PIN_OUT_HIGH
  } pin_mode_t;

  // ---------------------------------------------------------------
  // audio lanes and timing
  // ---------------------------------------------------------------
  localparam int LANE_A = 0;
  localparam int LANE_B = 1;
  localparam logic [3:0] LANES_NONE = 4'h0;
  localparam logic [3:0] LANES_A = 4'h1;
  localparam logic [3:0] LANES_AB = 4'h3;
  localparam logic [3:0] LANES_ALL = 4'hf;
  localparam int BCLK_MIN_KHZ = 1000;
  localparam int BCLK_MAX_KHZ = 13000;
  localparam int LINK_PERIOD_PS = 160000;
  // bit clock is the link clock halved: one toggle per rising link edge
  localparam int BCLK_DIV = 2;
  localparam int BCLK_KHZ = 1000000000 / (LINK_PERIOD_PS * BCLK_DIV);

endpackage

// [rtl/audio_ctrl_if.sv]
// control and local-pin carrier between the top and the audio lane driver
`timescale 1ns/1ps
interface audio_ctrl_if;
  logic [3:0] lane_en;
  logic use_local;
  logic [3:0] local_sd;
  logic local_ws;

  modport ctrl (output lane_en, output use_local, output local_sd, output local_ws);
  modport lane (input lane_en, input use_local, input local_sd, input local_ws);
endinterface

// [rtl/level_sync.sv]
// two-stage level synchroniser
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in, // destination clock
  input wire logic rst_in, // async reset, active high
  input wire logic [WIDTH-1:0] d_in, // level from another domain
  output logic [WIDTH-1:0] q_out // synchronised level
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stage1 <= '0;
      q_out <= '0;
    end else begin
      stage1 <= d_in;
      q_out <= stage1;
    end
  end
endmodule

// [rtl/audio_lane_out.sv]
// audio serial output lanes on the link clock
`timescale 1ns/1ps
module audio_lane_out
  import deser_pin_pkg::*;
(
  input wire logic link_clk_in, // link clock
  input wire logic rst_in, // async reset, active high
  audio_ctrl_if.lane ctrl, // lane enables and local pins
  input wire logic [3:0] link_sd_in, // lane bits from the link
  input wire logic link_ws_in, // word select from the link
  output logic bit_clk_out, // audio bit clock
  output logic ws_out, // word select, left/right slot
  output logic [3:0] sd_out // audio data lanes a..d
);
  logic [3:0] next_sd;
  logic next_ws;

  // ---------------------------------------------------------------
  // bit clock divider
  // ---------------------------------------------------------------
  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bit_clk_out <= 1'b0;
    end else begin
      bit_clk_out <= ~bit_clk_out;
    end
  end

  always_comb begin
    next_sd = ctrl.use_local ? ctrl.local_sd : link_sd_in;
    next_sd = next_sd & ctrl.lane_en;
    next_ws = ctrl.use_local ? ctrl.local_ws : link_ws_in;
  end

  // ---------------------------------------------------------------
  // lanes change on the falling bit clock edge
  // ---------------------------------------------------------------
  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sd_out <= '0;
      ws_out <= 1'b0;
    end else if (bit_clk_out) begin
      sd_out <= next_sd;
      ws_out <= (ctrl.lane_en != LANES_NONE) ? next_ws : 1'b0;
    end
  end
endmodule

// [test/deser_pin_checker_asserts.sv]
// concurrent checks on the pin-control block ports
`timescale 1ns/1ps
module deser_pin_checker
  import deser_pin_pkg::*;
(
  input wire logic sys_clk_in, // clock
  input wire logic sys_rst_in, // reset
  input wire logic link_clk_in, // link clock
  input wire logic reg_wr_in, // local write
  input wire logic reg_rd_in, // local read
  input wire logic [7:0] reg_addr_in, // local address
  input wire logic [7:0] reg_wdata_in, // local data
  input wire logic [7:0] reg_rdata_out, // read data
  input wire logic reg_rvalid_out, // read valid
  input wire logic rem_wr_in, // remote write
  input wire logic rem_rd_in, // remote read
  input wire logic rem_rvalid_out, // remote valid
  input wire logic rem_busy_out, // remote refused
  input wire logic backward_compat_select_in, // compat mode
  input wire logic [1:0] gpio01_pad_out, // pad value
  input wire logic [1:0] gpio01_pad_oe_out, // pad enable
  input wire logic audio_data_a_out, // lane a
  input wire logic audio_data_b_out // lane b
);
  // ---------------
  // sequences
  // ---------------
  sequence s_cfg(logic [7:0] a, logic [7:0] d);
    reg_wr_in && reg_addr_in == a && reg_wdata_in == d;
  endsequence
  sequence s_clash;
    (rem_wr_in || rem_rd_in) && (reg_wr_in || reg_rd_in);
  endsequence
  // ---------------
  // assertions
  // ---------------
  chk_read_answer: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    reg_rd_in |=> reg_rvalid_out) else $error("local read not answered");
  chk_stray_valid: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    reg_rvalid_out |-> $past(reg_rd_in)) else $error("read valid without read");
  chk_remote_refused: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    s_clash |-> rem_busy_out ##1 !rem_rvalid_out) else $error("clash not refused");
  chk_remote_answer: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    rem_rd_in && !reg_wr_in && !reg_rd_in |-> !rem_busy_out ##1 rem_rvalid_out)
    else $error("remote read not answered");
  chk_unmapped_zero: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    reg_rd_in && reg_addr_in inside {[8'h00:8'h1c], [8'h22:8'h6d], [8'h70:8'hff]}
    |=> reg_rdata_out == RDATA_UNMAPPED) else $error("unmapped read not zero");
  chk_drive_high: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    s_cfg(ADDR_GPIO0_CONFIG, 8'h09) |-> ##[1:3] gpio01_pad_oe_out[0] && gpio01_pad_out[0])
    else $error("pin 0 not driven high");
  chk_drive_low: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    s_cfg(ADDR_GPIO0_CONFIG, 8'h01) |-> ##[1:3] gpio01_pad_oe_out[0] && !gpio01_pad_out[0])
    else $error("pin 0 not driven low");
  chk_input_released: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    s_cfg(ADDR_GPIO0_CONFIG, 8'h03) |-> ##[1:3] !gpio01_pad_oe_out[0])
    else $error("pin 0 input still driven");
  // compat crosses domains: allow sync and one bit slot
  chk_no_audio: assert property (@(posedge link_clk_in) disable iff (sys_rst_in)
    backward_compat_select_in [*8] |-> !audio_data_a_out && !audio_data_b_out)
    else $error("audio in compat mode");
endmodule
bind deser_gpio_audio_pin_control deser_pin_checker i_deser_pin_checker (.sys_clk_in,
  .sys_rst_in, .link_clk_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
  .reg_rdata_out, .reg_rvalid_out, .rem_wr_in, .rem_rd_in, .rem_rvalid_out, .rem_busy_out,
  .backward_compat_select_in, .gpio01_pad_out, .gpio01_pad_oe_out, .audio_data_a_out,
  .audio_data_b_out);

// [test/link_far_end.sv]
// far end of the link: sends forward pin levels, captures back-channel levels
`timescale 1ns/1ps
module link_far_end (
  input wire logic link_clk_in, // link clock
  input wire logic [3:0] fwd_level_in, // levels to send
  output logic [3:0] fwd_gpio_out, // forward pin levels
  input wire logic [3:0] bc_gpio_in, // back-channel levels
  input wire logic [3:0] bc_valid_in, // back-channel pins in use
  output logic [3:0] bc_seen_out // captured levels
);
  initial {fwd_gpio_out, bc_seen_out} = '0;
  always @(posedge link_clk_in) begin
    fwd_gpio_out <= fwd_level_in;
    bc_seen_out <= bc_gpio_in & bc_valid_in;
  end
endmodule

// [test/tb.sv]
// self-checking bench for the pin-control block
`timescale 1ns/1ps
module tb;
  import deser_pin_pkg::*;
  logic sys_clk_in, sys_rst_in, link_clk_in, reg_wr_in, reg_rd_in, rem_wr_in, rem_rd_in;
  logic [7:0] reg_addr_in, reg_wdata_in, rem_addr_in, rem_wdata_in, reg_rdata_out;
  logic [7:0] rem_rdata_out, rd_q;
  logic reg_rvalid_out, rem_rvalid_out, rem_busy_out, audio_in_ws_in, link_audio_ws_in;
  logic backward_compat_select_in, ser_full_feature_in, ser_18bit_mode_in;
  logic ser_island_mode_in, audio_cfg_disable_in, surround_en_in, repeater_mode_in;
  logic [3:0] fwd_gpio_in, bc_gpio_out, bc_gpio_valid_out, fwd_level, bc_seen;
  logic [1:0] gpio01_pad_in, gpio01_pad_out, gpio01_pad_oe_out, cd_pad_in, cd_pad_out;
  logic [1:0] cd_pad_oe_out;
  logic [3:0] reg_pad_in, reg_pad_out, reg_pad_oe_out, link_audio_sd_in;
  logic audio_bit_clk_out, audio_word_select_out, audio_data_a_out, audio_data_b_out;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  deser_gpio_audio_pin_control i_deser_gpio_audio_pin_control (.sys_clk_in, .sys_rst_in,
    .link_clk_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
    .reg_rvalid_out, .rem_wr_in, .rem_rd_in, .rem_addr_in, .rem_wdata_in, .rem_rdata_out,
    .rem_rvalid_out, .rem_busy_out, .backward_compat_select_in, .ser_full_feature_in,
    .ser_18bit_mode_in, .ser_island_mode_in, .audio_cfg_disable_in, .surround_en_in,
    .repeater_mode_in, .fwd_gpio_in, .bc_gpio_out, .bc_gpio_valid_out, .gpio01_pad_in,
    .gpio01_pad_out, .gpio01_pad_oe_out, .cd_pad_in, .cd_pad_out, .cd_pad_oe_out,
    .reg_pad_in, .reg_pad_out, .reg_pad_oe_out, .audio_in_ws_in, .audio_bit_clk_out,
    .audio_word_select_out, .audio_data_a_out, .audio_data_b_out, .link_audio_sd_in,
    .link_audio_ws_in);
  link_far_end i_link_far_end (.link_clk_in, .fwd_level_in(fwd_level),
    .fwd_gpio_out(fwd_gpio_in), .bc_gpio_in(bc_gpio_out), .bc_valid_in(bc_gpio_valid_out),
    .bc_seen_out(bc_seen));
  // ---------------
  // clocks, timeout, helpers
  // ---------------
  initial begin
    sys_clk_in = 1'h0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  // phase unrelated to sys_clk_in
  initial begin
    link_clk_in = 1'h0;
    #37;
    forever #80 link_clk_in = ~link_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input bit rem, input logic [7:0] a, input logic [7:0] d);
    rem_wr_in <= rem;
    reg_wr_in <= !rem;
    {rem_addr_in, rem_wdata_in, reg_addr_in, reg_wdata_in} <= {a, d, a, d};
    @(posedge sys_clk_in);
    {rem_wr_in, reg_wr_in} <= 2'h0;
    repeat (3) @(posedge sys_clk_in);
  endtask
  task automatic rd(input bit rem, input logic [7:0] a, output logic [7:0] d);
    rem_rd_in <= rem;
    reg_rd_in <= !rem;
    {rem_addr_in, reg_addr_in} <= {a, a};
    @(posedge sys_clk_in);
    {rem_rd_in, reg_rd_in} <= 2'h0;
    #1;
    check("read valid", 32'h1, rem ? rem_rvalid_out : reg_rvalid_out);
    d = rem ? rem_rdata_out : reg_rdata_out;
    @(posedge sys_clk_in);
  endtask
  task automatic report_and_stop;
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ---------------
  // scenarios
  // ---------------
  task automatic t_reset_and_unmapped;
    for (int a = 8'h1d; a <= 8'h21; a++) begin
      rd(0, 8'(a), rd_q);
      check("config reset", CONFIG_RESET, rd_q);
    end
    wr(0, 8'h30, 8'hff);
    rd(0, 8'h30, rd_q);
    check("unmapped", RDATA_UNMAPPED, rd_q);
  endtask
  task automatic t_outputs;
    wr(0, 8'h1d, 8'h09);
    check("pin0 high", 32'h3, {gpio01_pad_oe_out[0], gpio01_pad_out[0]});
    wr(0, 8'h1d, 8'h01);
    check("pin0 low", 32'h2, {gpio01_pad_oe_out[0], gpio01_pad_out[0]});
    wr(0, 8'h1e, 8'h19);
    check("pin1 pin2", 32'he, {gpio01_pad_oe_out[1], gpio01_pad_out[1], cd_pad_oe_out[0],
      cd_pad_out[0]});
    wr(0, 8'h20, 8'h19);
    wr(1, 8'h21, 8'h91);
    check("reg pins", 32'hf9, {reg_pad_oe_out, reg_pad_out});
    wr(0, 8'h20, 8'h55);
    check("code 5 off", 32'hc, reg_pad_oe_out);
  endtask
  task automatic t_status;
    logic [7:0] lv;
    wr(0, 8'h1d, 8'h03);
    for (int a = 'h1e; a <= 'h21; a++) wr(0, 8'(a), 8'h33);
    check("inputs released", 32'h0, {gpio01_pad_oe_out, cd_pad_oe_out, reg_pad_oe_out});
    for (int i = 0; i < 2; i++) begin
      lv = i ? 8'h5a : 8'ha5;
      {reg_pad_in, cd_pad_in, gpio01_pad_in} <= lv;
      repeat (4) @(posedge sys_clk_in);
      rd(0, ADDR_INPUT_LEVELS_LOW, rd_q);
      check("status low", {lv[6:4], 1'h0, lv[3:0]}, rd_q);
      rd(1, ADDR_INPUT_LEVELS_HIGH, rd_q);
      check("status high", {7'h0, lv[7]}, rd_q);
    end
  endtask
  task automatic t_link;
    wr(0, 8'h1e, 8'h55);
    wr(0, 8'h1f, 8'h05);
    wr(1, 8'h1d, 8'h03);
    for (int i = 0; i < 2; i++) begin
      fwd_level <= i ? 4'h0 : 4'hf;
      gpio01_pad_in <= i ? 2'h0 : 2'h1;
      repeat (400) @(posedge sys_clk_in);
      #1;
      check("forward", i ? 32'h2c : 32'h3f, {gpio01_pad_oe_out[1], gpio01_pad_out[1],
        cd_pad_oe_out, cd_pad_out});
      check("back channel", i ? 32'h0 : 32'h1, bc_seen);
      @(posedge sys_clk_in);
    end
  endtask
  task automatic t_remote_clash;
    wr(1, 8'h1f, 8'h09);
    rem_wr_in <= 1'h1;
    {rem_addr_in, rem_wdata_in, reg_addr_in} <= {8'h1f, 8'h01, 8'h1f};
    reg_rd_in <= 1'h1;
    #1;
    check("remote refused", 32'h1, rem_busy_out);
    @(posedge sys_clk_in);
    {rem_wr_in, reg_rd_in} <= 2'h0;
    repeat (2) @(posedge sys_clk_in);
    rd(1, 8'h1f, rd_q);
    check("dropped write", 32'h9, rd_q);
  endtask
  task automatic t_audio;
    logic [7:0] cs [7] = '{8'hd0, 8'h57, 8'h59, 8'h11, 8'h33, 8'h41, 8'h52};
    time t0;
    wr(0, 8'h20, 8'h00);
    repeater_mode_in <= 1'h1;
    reg_pad_in <= 4'hf;
    for (int i = 0; i < 7; i++) begin
      if (i == 6) begin
        wr(0, 8'h20, 8'h03);
      end
      {backward_compat_select_in, ser_full_feature_in, ser_18bit_mode_in, ser_island_mode_in,
        audio_cfg_disable_in, surround_en_in} <= cs[i][7:2];
      repeat (600) @(posedge sys_clk_in);
      #1;
      check("lanes ws b a", {!cs[i][7], cs[i][1:0]}, {audio_word_select_out, audio_data_b_out,
        audio_data_a_out});
    end
    @(posedge audio_bit_clk_out);
    t0 = $time;
    @(posedge audio_bit_clk_out);
    check("bit clock period", 32'h140, 32'($time - t0));
    @(posedge sys_clk_in);
  endtask
  // ---------------
  // main sequence
  // ---------------
  initial begin
    {reg_wr_in, reg_rd_in, rem_wr_in, rem_rd_in, reg_addr_in, reg_wdata_in} = '0;
    {rem_addr_in, rem_wdata_in, audio_in_ws_in, fwd_level, gpio01_pad_in} = '0;
    {cd_pad_in, reg_pad_in, backward_compat_select_in, ser_full_feature_in} = '0;
    {ser_18bit_mode_in, ser_island_mode_in, audio_cfg_disable_in} = '0;
    {surround_en_in, repeater_mode_in, link_audio_sd_in, link_audio_ws_in} = '0;
    sys_rst_in = 1'h1;
    repeat (12) @(posedge link_clk_in);
    @(posedge sys_clk_in);
    sys_rst_in <= 1'h0;
    audio_in_ws_in <= 1'h1;
    @(posedge sys_clk_in);
    t_reset_and_unmapped();
    t_outputs();
    t_status();
    t_link();
    t_remote_clash();
    t_audio();
    report_and_stop();
  end
endmodule
